// File: design/rcsc_top.sv
`timescale 1ns/1ps
module rcsc_top
  import rcsc_pkg::*;
#(
  parameter int PWRT_CYCLES = PWRT_CYC,
  parameter int VREG_CYCLES = VREG_CYC
)(
  input  wire logic        i_clk,
  input  wire logic        i_arst_n,
  input  wire logic        i_por,            // power-on event pulse (pin)
  input  wire logic        i_brownout,       // supply below threshold (pin)
  input  wire logic        i_master_clear_input_n, // external clear pin
  input  wire logic        i_regulator_en,
  input  wire logic        i_pll_en,
  input  wire logic        i_osc_ready,      // pin
  input  wire logic        i_pll_lock,       // pin
  input  wire logic        i_sw_reset,       // core pulses
  input  wire logic        i_wdt_timeout,
  input  wire logic        i_illegal_op,
  input  wire logic        i_uninit_ptr,
  input  wire logic        i_cfg_mismatch,
  input  wire logic        i_cfg_parity_err,
  input  wire logic        i_trap_event,
  input  wire logic        i_trap_clear,
  input  wire logic        i_stack_err,
  input  wire logic        i_enter_sleep,
  input  wire logic        i_enter_idle,
  input  wire logic        i_wake_irq,
  input  wire logic [2:0]  i_irq_prio,
  input  wire logic [2:0]  i_cpu_prio,
  input  wire logic [22:0] i_pc,
  input  wire logic [22:0] i_irq_vector,
  input  wire logic        i_rst_ctl_we,     // software write of the register
  input  wire logic [15:0] i_rst_ctl_wdata,
  input  wire logic        i_stack_flag_clr, // software writes zero
  output logic [15:0]      o_reset_control_register,
  output logic             o_stack_error_flag,
  output logic             o_core_reset,
  output logic             o_sfr_reset,      // returns other registers to default
  output logic             o_pc_load,
  output logic [22:0]      o_pc_value,
  output logic             o_brownout_reset
);
  logic [1:0] rst_sync;
  logic       rst_n;
  logic [1:0] s_por, s_brown, s_clr_pin, s_osc, s_pll;
  logic       por_s, brown_s, clr_pin_n_s, osc_s, pll_s;
  logic       trap_pending;
  rcsc_state_t state, next_state;
  logic       tmr_load;
  logic [CNT_W-1:0] tmr_val;
  logic       tmr_done;
  logic [15:0] rst_ctl;
  logic       stack_flag;
  logic       asleep;
  logic       pc_load;
  logic [22:0] pc_value;

  // ****************************************
  // reset release and pin synchronisers
  // ****************************************
  always_ff @(posedge i_clk or negedge i_arst_n)
  begin
    if (!i_arst_n)
    begin
      rst_sync <= 2'h0;
      s_por    <= 2'h0;
      s_brown  <= 2'h0;
      s_clr_pin <= 2'h3;
      s_osc    <= 2'h0;
      s_pll    <= 2'h0;
    end
    else
    begin
      rst_sync <= {rst_sync[0], 1'b1};
      s_por    <= {s_por[0], i_por};
      s_brown  <= {s_brown[0], i_brownout};
      s_clr_pin <= {s_clr_pin[0], i_master_clear_input_n};
      s_osc    <= {s_osc[0], i_osc_ready};
      s_pll    <= {s_pll[0], i_pll_lock};
    end
  end
  assign rst_n    = rst_sync[1];
  assign por_s    = s_por[1];
  assign brown_s  = s_brown[1] && i_regulator_en;
  assign clr_pin_n_s = s_clr_pin[1];

  assign osc_s    = s_osc[1];
  assign pll_s    = s_pll[1];

  // ****************************************
  // reset causes
  // ****************************************
  wire ev_iop   = i_illegal_op || i_uninit_ptr;
  wire ev_cfg   = i_cfg_mismatch || i_cfg_parity_err;
  wire ev_trap  = i_trap_event && trap_pending;
  wire ev_clr   = !clr_pin_n_s;                           // pin always a reset
  wire ev_power = por_s || brown_s;
  // stack error is deliberately absent: it is a trap only
  wire ev_any   = ev_power || ev_clr || i_sw_reset || i_wdt_timeout ||
                  ev_iop || ev_cfg || ev_trap;
  // wdt in sleep or idle wakes instead of resetting
  wire wdt_wake = i_wdt_timeout && asleep;
  wire do_reset = ev_any && !(wdt_wake && !(ev_power || ev_clr || i_sw_reset ||
                  ev_iop || ev_cfg || ev_trap));

  // ****************************************
  // first trap pending tracker
  // ****************************************
  always_ff @(posedge i_clk or negedge rst_n)
  begin
    if (!rst_n)
      trap_pending <= 1'b0;
    else if (do_reset)
      trap_pending <= 1'b0;
    else if (i_trap_event || i_stack_err)
      trap_pending <= 1'b1;              // a new trap wins over a clear
    else if (i_trap_clear)
      trap_pending <= 1'b0;
  end

  // ****************************************
  // flag register: sets beat software clears
  // ****************************************
  logic [15:0] set_mask;
  logic [15:0] clr_mask;
  always_comb
  begin
    set_mask = 16'h0000;
    set_mask[RCB_POR]   = por_s;
    set_mask[RCB_BROWN] = brown_s;
    set_mask[RCB_EXTR]  = ev_clr;
    set_mask[RCB_SWR]   = i_sw_reset;
    set_mask[RCB_WDTO]  = i_wdt_timeout;
    set_mask[RCB_IOP]   = ev_iop;
    set_mask[RCB_CFGMIS] = ev_cfg;
    set_mask[RCB_TRAP]  = ev_trap;
    set_mask[RCB_SLEEP] = i_enter_sleep;
    set_mask[RCB_IDLE]  = i_enter_idle;
    // software writes only clear flags; the standby bit is a plain control
    clr_mask = (i_rst_ctl_we ? ~i_rst_ctl_wdata : 16'h0000) & RSTCTL_FLAGS;
  end

  // flags survive wake-ups and resets other than the asynchronous one
  always_ff @(posedge i_clk or negedge rst_n)
  begin
    if (!rst_n)
      rst_ctl <= RSTCTL_RST;
    else
    begin
      rst_ctl <= ((rst_ctl & ~clr_mask) | set_mask) & (RSTCTL_FLAGS | 16'h0100);
      if (i_rst_ctl_we)
        rst_ctl[RCB_STBY] <= i_rst_ctl_wdata[RCB_STBY];
    end
  end

  // stack error flag in interrupt control one, set wins
  always_ff @(posedge i_clk or negedge rst_n)
  begin
    if (!rst_n)
      stack_flag <= 1'b0;
    else if (i_stack_err)
      stack_flag <= 1'b1;
    else if (i_stack_flag_clr || do_reset)
      stack_flag <= 1'b0;
  end

  // power-saving state kept apart from the sleep and idle flags, which only software clears
  always_ff @(posedge i_clk or negedge rst_n)
  begin
    if (!rst_n)
      asleep <= 1'b0;
    else if (do_reset)
      asleep <= 1'b0;
    else if (i_enter_sleep || i_enter_idle)
      asleep <= 1'b1;
    else if (i_wake_irq || wdt_wake)
      asleep <= 1'b0;
  end

  // ****************************************
  // start-up sequencer
  // ****************************************
  wire [CNT_W-1:0] pwr_dly = PWRT_CYCLES[CNT_W-1:0];
  wire [CNT_W-1:0] reg_dly = VREG_CYCLES[CNT_W-1:0];
  // a power event arms the hold for the present regulator setting, from any state
  assign tmr_val  = (do_reset && ev_power && !i_regulator_en) ? pwr_dly : reg_dly;
  assign tmr_load = (do_reset && ev_power) || (state == ST_HOLD && tmr_done &&
                    !rst_ctl[RCB_STBY] && i_regulator_en);

  rcsc_timer #(
    .W (CNT_W)
  ) u_timer (
    .i_clk   (i_clk),
    .i_rst_n (rst_n),
    .i_load  (tmr_load),
    .i_value (tmr_val),
    .o_done  (tmr_done)
  );

  always_comb
  begin
    next_state = state;
    case (state)
      ST_HOLD:
        if (tmr_done)
          next_state = (!rst_ctl[RCB_STBY] && i_regulator_en) ? ST_SETTL : ST_OSC;
      ST_SETTL:
        if (tmr_done)
          next_state = ST_OSC;
      ST_OSC:
        if (osc_s)
          next_state = i_pll_en ? ST_PLL : ST_RUN;
      ST_PLL:
        if (pll_s)
          next_state = ST_RUN;
      ST_RUN:
        next_state = ST_RUN;
      default:
        next_state = ST_HOLD;
    endcase
    if (do_reset)
      next_state = ev_power ? ST_HOLD : ST_OSC;
  end

  always_ff @(posedge i_clk or negedge rst_n)
  begin
    if (!rst_n)
      state <= ST_HOLD;
    else
      state <= next_state;
  end

  // power-on path also needs the hold timer armed at release
  // (timer starts at zero, so a first hold is covered by loading on por)

  // ****************************************
  // program counter steering
  // ****************************************
  wire wake     = (i_wake_irq && asleep) || wdt_wake;
  wire irq_take = i_wake_irq && (i_irq_prio > i_cpu_prio);
  always_ff @(posedge i_clk or negedge rst_n)
  begin
    if (!rst_n)
    begin
      pc_load  <= 1'b0;
      pc_value <= RESET_VECTOR;
    end
    else
    begin
      pc_load <= do_reset || wake || i_stack_err;
      if (do_reset)
        pc_value <= RESET_VECTOR;
      else if (i_stack_err)
        pc_value <= STACK_VECTOR;
      else if (wake)
        pc_value <= irq_take ? i_irq_vector : i_pc + PC_STEP;
    end
  end

  // ****************************************
  // outputs
  // ****************************************
  assign o_reset_control_register = rst_ctl;
  assign o_stack_error_flag       = stack_flag;
  assign o_core_reset             = (state != ST_RUN) || ev_clr;
  assign o_sfr_reset              = do_reset;             // wake never clears
  assign o_pc_load                = pc_load;
  assign o_pc_value               = pc_value;
  assign o_brownout_reset         = brown_s;
endmodule : rcsc_top

// File: design/rcsc_pkg.sv
// Contract
// - interrupt wake resumes at pc plus 2 unless priority above cpu level
// - illegal opcode or uninitialized pointer use resets and sets its flag
// - config word mismatch or parity error resets and sets its flag
// - second trap before first cleared gives trap conflict reset and flag
// - stack error is a soft trap to vector 000Ah, never a reset
// - brown-out reset is active whenever the regulator is enabled
// - any reset returns registers to one default, reset-control excepted
// - wake from power saving leaves register contents unchanged
// - power-on or brown-out holds reset 64 ms, or 10 us with regulator
// - extra regulator settle delay when regulator standby keep bit clear
// - then wait oscillator start-up and pll lock when pll enabled
// - master clear input always resets, never a general input
// - status flags are active high, set when their event occurs
// - ten flags in reset control, stack error in interrupt control one
// - separate sleep and idle flags record power saving entry
package rcsc_pkg;

  // ****************************************
  // reset control register bit positions
  // ****************************************
  localparam int RCB_POR    = 0;
  localparam int RCB_BROWN  = 1;
  localparam int RCB_IDLE   = 2;
  localparam int RCB_SLEEP  = 3;
  localparam int RCB_WDTO   = 4;
  localparam int RCB_SWR    = 5;
  localparam int RCB_EXTR   = 6;
  localparam int RCB_CFGMIS = 9;
  localparam int RCB_IOP    = 14;
  localparam int RCB_TRAP   = 15;
  localparam int RCB_STBY   = 8;
  localparam logic [15:0] RSTCTL_RST   = 16'h0000;
  localparam logic [15:0] RSTCTL_FLAGS = 16'hC27F;  // sticky status flags

  // ****************************************
  // vectors and timing
  // ****************************************
  localparam logic [22:0] RESET_VECTOR = 23'h000000;
  localparam logic [22:0] STACK_VECTOR = 23'h00000A;
  localparam logic [22:0] PC_STEP      = 23'h000002;
  localparam int CLK_HZ           = 25000000;
  localparam int PWRT_MS          = 64;
  localparam int VREG_US          = 10;
  localparam int PWRT_CYC         = PWRT_MS * (CLK_HZ / 1000);
  localparam int VREG_CYC         = (VREG_US * (CLK_HZ / 1000) + 999) / 1000;
  localparam int CNT_W            = 32;

  typedef enum logic [4:0] {
    ST_HOLD  = 5'b00001,
    ST_SETTL = 5'b00010,
    ST_OSC   = 5'b00100,
    ST_PLL   = 5'b01000,
    ST_RUN   = 5'b10000
  } rcsc_state_t;

endpackage : rcsc_pkg

// File: design/rcsc_timer.sv
`timescale 1ns/1ps
// one-shot down counter: load then counts to zero, done while zero
module rcsc_timer
  import rcsc_pkg::*;
#(
  parameter int W = CNT_W
)(
  input  wire logic         i_clk,
  input  wire logic         i_rst_n,
  input  wire logic         i_load,
  input  wire logic [W-1:0] i_value,
  output logic              o_done
);
  logic [W-1:0] cnt;

  // ****************************************
  // counter
  // ****************************************
  always_ff @(posedge i_clk or negedge i_rst_n)
  begin
    if (!i_rst_n)
      cnt <= '0;
    else if (i_load)
      cnt <= i_value;
    else if (cnt != '0)
      cnt <= cnt - {{(W-1){1'b0}}, 1'b1};
  end

  // plain zero test: a done that looked at load would loop back through the load decision
  assign o_done = (cnt == '0);
endmodule : rcsc_timer

// File: test/rcsc_top_asserts.sv
`timescale 1ns/1ps
module rcsc_top_asserts
  import rcsc_pkg::*;
(
  input  wire logic        i_clk,
  input  wire logic        i_arst_n,
  input  wire logic        i_brownout,
  input  wire logic        i_master_clear_input_n,
  input  wire logic        i_regulator_en,
  input  wire logic        i_illegal_op,
  input  wire logic        i_uninit_ptr,
  input  wire logic        i_cfg_mismatch,
  input  wire logic        i_cfg_parity_err,
  input  wire logic        i_trap_event,
  input  wire logic        i_trap_clear,
  input  wire logic        i_stack_err,
  input  wire logic        i_wake_irq,
  input  wire logic [2:0]  i_irq_prio,
  input  wire logic [2:0]  i_cpu_prio,
  input  wire logic [22:0] i_pc,
  input  wire logic [22:0] i_irq_vector,
  input  wire logic        i_rst_ctl_we,
  input  wire logic [15:0] o_reset_control_register,
  input  wire logic        o_stack_error_flag,
  input  wire logic        o_core_reset,
  input  wire logic        o_sfr_reset,
  input  wire logic        o_pc_load,
  input  wire logic [22:0] o_pc_value,
  input  wire logic        o_brownout_reset
);
  default clocking @(posedge i_clk); endclocking
  default disable iff (!i_arst_n);
  wire logic [15:0] rc;
  wire logic        wake_low;
  // ****************
  // event sequences
  // ****************
  assign rc = o_reset_control_register;
  assign wake_low = i_wake_irq && i_irq_prio <= i_cpu_prio;
  sequence s_bad_op; i_illegal_op || i_uninit_ptr; endsequence
  sequence s_two_traps;
    i_trap_event ##1 (!i_trap_clear && !i_trap_event)[*2] ##1 i_trap_event;
  endsequence
  sequence s_clr_held; (!i_master_clear_input_n)[*3]; endsequence
  // ****************
  // properties
  // ****************
  chk_illegal_flag:
    assert property (s_bad_op |=> rc[RCB_IOP]) else $error("illegal op flag missing");
  chk_bad_op_vector:
    assert property (s_bad_op |-> o_sfr_reset ##1 (o_pc_load && o_pc_value == RESET_VECTOR))
    else $error("reset entry wrong");
  chk_cfg_flag:
    assert property (i_cfg_mismatch || i_cfg_parity_err |=> rc[RCB_CFGMIS])
    else $error("config flag missing");
  chk_trap_conflict:
    assert property (s_two_traps |=> rc[RCB_TRAP]) else $error("trap conflict flag missing");
  chk_stack_soft:
    assert property (i_stack_err && !o_core_reset |-> !o_sfr_reset ##1 (!o_core_reset
      && o_stack_error_flag && o_pc_load && o_pc_value == STACK_VECTOR))
    else $error("stack trap wrong");
  chk_brownout_tie:
    assert property (i_arst_n[*5] |-> o_brownout_reset == (i_regulator_en && $past(i_brownout, 2)))
    else $error("brownout reset level wrong");
  chk_clear_pin:
    assert property (s_clr_held |-> ##[0:3] (o_core_reset && rc[RCB_EXTR]))
    else $error("clear pin ignored");
  chk_flags_sticky:
    assert property (!i_rst_ctl_we |=> (rc & $past(rc) & RSTCTL_FLAGS)
      == ($past(rc) & RSTCTL_FLAGS)) else $error("flag lost");
  chk_wake_resume:
    assert property (wake_low |-> !o_sfr_reset ##1 (o_pc_load && o_pc_value == $past(i_pc)
      + PC_STEP)) else $error("wake resume wrong");
  chk_wake_vector:
    assert property (i_wake_irq && !wake_low |=> o_pc_load && o_pc_value == $past(i_irq_vector))
    else $error("wake vector wrong");
endmodule : rcsc_top_asserts

// File: test/rcsc_clock_model.sv
`timescale 1ns/1ps
// oscillator and pll start-up; power-on stops both, so ready and lock fall at once
module rcsc_clock_model (
  input  wire logic i_clk,
  input  wire logic i_restart,
  input  wire logic i_pll_en,
  input  wire logic i_slow,
  output logic      o_osc_ready,
  output logic      o_pll_lock
);
  int cnt = 0;
  // saturating age counter of the running oscillator
  always @(posedge i_clk)
    if (i_restart) cnt <= 0;
    else if (cnt < 2000) cnt <= cnt + 1;
  assign o_osc_ready = cnt >= (i_slow ? 700 : 20);
  assign o_pll_lock = i_pll_en && cnt >= (i_slow ? 760 : 40);
endmodule : rcsc_clock_model

// File: test/tb_rcsc_top.sv
`timescale 1ns/1ps
module tb_rcsc_top
  import rcsc_pkg::*;
;
  logic        i_clk = 0, i_arst_n = 0, i_por = 0, i_brownout = 0, i_regulator_en = 0;
  logic        i_pll_en = 0, i_trap_clear = 0, i_rst_ctl_we = 0, i_stack_flag_clr = 0, slow = 0;
  logic [2:0]  i_irq_prio = '0, i_cpu_prio = '0;
  logic [22:0] i_pc = '0, i_irq_vector = '0;
  logic [15:0] i_rst_ctl_wdata = '0, exp;
  logic [11:0] ev = '0;
  wire         i_osc_ready, i_pll_lock, stk_f, core_rst, bo_rst;
  wire  [15:0] rc;
  wire  [22:0] pc_v;
  int          mismatches = 0, comparisons = 0, n;
  int          bitp[7] = '{RCB_IOP, RCB_IOP, RCB_CFGMIS, RCB_CFGMIS,
                           RCB_SWR, RCB_WDTO, RCB_EXTR};
  // short count keeps the power hold test brief
  rcsc_top #(.PWRT_CYCLES(100), .VREG_CYCLES(250)) u_dut (.i_clk, .i_arst_n, .i_por,
    .i_brownout, .i_master_clear_input_n(~ev[6]), .i_regulator_en, .i_pll_en, .i_osc_ready,
    .i_pll_lock, .i_sw_reset(ev[4]), .i_wdt_timeout(ev[5]), .i_illegal_op(ev[0]),
    .i_uninit_ptr(ev[1]), .i_cfg_mismatch(ev[2]), .i_cfg_parity_err(ev[3]),
    .i_trap_event(ev[7]), .i_trap_clear, .i_stack_err(ev[8]), .i_enter_sleep(ev[9]),
    .i_enter_idle(ev[10]), .i_wake_irq(ev[11]), .i_irq_prio, .i_cpu_prio, .i_pc,
    .i_irq_vector, .i_rst_ctl_we, .i_rst_ctl_wdata, .i_stack_flag_clr,
    .o_reset_control_register(rc), .o_stack_error_flag(stk_f), .o_core_reset(core_rst),
    .o_sfr_reset(), .o_pc_load(), .o_pc_value(pc_v), .o_brownout_reset(bo_rst));
  rcsc_clock_model u_osc (.i_clk, .i_restart(i_por), .i_pll_en, .i_slow(slow),
    .o_osc_ready(i_osc_ready), .o_pll_lock(i_pll_lock));
  // ****************
  // helpers
  // ****************
  initial forever #20 i_clk = ~i_clk;
  task automatic chk(string nm, logic [31:0] got, logic [31:0] want);
    comparisons++;
    if (got !== want)
    begin
      mismatches++;
      $display("[ERR] %s expected %0h seen %0h", nm, want, got);
    end
  endtask : chk
  task automatic end_of_test;
    $display("comparisons %0d mismatches %0d", comparisons, mismatches);
    if (mismatches == 0 && comparisons > 0)
      $display("*** PASS ***");
    else
      $display("*** FAIL ***");
    $finish;
  endtask : end_of_test
  // events are single pulses, the clear pin is held longer
  task automatic pulse(int b, int len);
    @(negedge i_clk) ev[b] = 1'b1;
    repeat (len) @(negedge i_clk);
    ev[b] = 1'b0;
  endtask : pulse
  task automatic run_wait();
    while (core_rst !== 1'b0 && n < 3000)
    begin
      @(negedge i_clk);
      n++;
    end
    chk("core released", n < 3000, 1'b1);
  endtask : run_wait
  task automatic wr(logic [15:0] d);
    @(negedge i_clk) i_rst_ctl_we = 1'b1;
    i_rst_ctl_wdata = d;
    @(negedge i_clk) i_rst_ctl_we = 1'b0;
  endtask : wr
  task automatic startup(logic r, logic p, logic s, int lo, int hi);
    @(negedge i_clk) i_regulator_en = r;
    i_pll_en = p;
    slow = s;
    i_por = 1'b1;
    @(negedge i_clk) i_por = 1'b0;
    // the pin pulse needs its two sync stages before the sequencer drops into hold
    repeat (2) @(negedge i_clk);
    n = 3;
    run_wait();
    chk("hold too short", n >= lo, 1'b1);
    chk("hold too long", n <= hi, 1'b1);
    chk("clock ready", {i_osc_ready, i_pll_lock}, {1'b1, p});
    chk("power flag", rc[RCB_POR], 1'b1);
  endtask : startup
  // ****************
  // tests
  // ****************
  initial
  begin
    repeat (3) @(posedge i_clk);
    @(negedge i_clk) i_arst_n = 1'b1;
    repeat (3) @(negedge i_clk);
    chk("flags", {stk_f, rc}, '0);
    $display("reset test done");
    startup(1'b0, 1'b0, 1'b0, 100, 140);
    startup(1'b1, 1'b0, 1'b0, 500, 540);
    startup(1'b1, 1'b1, 1'b1, 760, 800);
    wr(16'h0100);
    startup(1'b1, 1'b0, 1'b0, 250, 290);
    $display("startup test done");
    @(negedge i_clk) i_brownout = 1'b1;
    repeat (4) @(negedge i_clk);
    chk("brownout", bo_rst, 1'b1);
    i_brownout = 1'b0;
    n = 0;
    run_wait();
    chk("brownout flag", rc[RCB_BROWN], 1'b1);
    i_regulator_en = 1'b0;
    i_brownout = 1'b1;
    repeat (4) @(negedge i_clk);
    chk("no brownout", bo_rst, 1'b0);
    i_brownout = 1'b0;
    $display("brownout test done");
    wr(16'h0000);
    exp = 16'h0000;
    for (int k = 0; k < 7; k++)
    begin
      pulse(k, k == 6 ? 4 : 1);
      repeat (2) @(negedge i_clk);
      n = 0;
      run_wait();
      exp[bitp[k]] = 1'b1;
      chk("event flags", rc, exp);
    end
    wr(16'h0000);
    chk("cleared", rc, 16'h0000);
    $display("event test done");
    pulse(7, 1);
    @(negedge i_clk);
    pulse(7, 1);
    repeat (2) @(negedge i_clk);
    n = 0;
    run_wait();
    chk("trap flags", rc, 16'h8000);
    @(negedge i_clk) i_trap_clear = 1'b1;
    @(negedge i_clk) i_trap_clear = 1'b0;
    pulse(8, 1);
    chk("stack trap", {core_rst, stk_f, pc_v}, {2'b01, STACK_VECTOR});
    chk("stack no flag", rc, 16'h8000);
    @(negedge i_clk) i_trap_clear = 1'b1;
    i_stack_flag_clr = 1'b1;
    @(negedge i_clk) i_trap_clear = 1'b0;
    i_stack_flag_clr = 1'b0;
    chk("stack clear", stk_f, 1'b0);
    $display("trap test done");
    i_cpu_prio = 3'h3;
    i_pc = 23'h000100;
    i_irq_vector = 23'h000040;
    for (int k = 0; k < 2; k++)
    begin
      pulse(9 + k, 1);
      chk("power mode flag", rc[RCB_SLEEP - k], 1'b1);
      i_irq_prio = k ? 3'h4 : 3'h3;
      pulse(11, 1);
      chk("wake pc", pc_v, k ? 23'h000040 : 23'h000102);
      chk("wake keeps state", {core_rst, rc}, {1'b0, (k ? 16'h800C : 16'h8008)});
    end
    pulse(9, 1);
    pulse(5, 1);
    chk("wdt wake pc", {core_rst, pc_v}, {1'b0, 23'h000102});
    $display("wake test done");
    end_of_test();
  end
  // hang guard, far beyond the few thousand cycles the tests need
  initial
  begin
    #(40 * 20000);
    mismatches++;
    end_of_test();
  end
endmodule : tb_rcsc_top
bind rcsc_top rcsc_top_asserts u_chk (.i_clk, .i_arst_n, .i_brownout, .i_master_clear_input_n,
  .i_regulator_en, .i_illegal_op, .i_uninit_ptr, .i_cfg_mismatch, .i_cfg_parity_err,
  .i_trap_event, .i_trap_clear, .i_stack_err, .i_wake_irq, .i_irq_prio, .i_cpu_prio, .i_pc,
  .i_irq_vector, .i_rst_ctl_we, .o_reset_control_register, .o_stack_error_flag, .o_core_reset,
  .o_sfr_reset, .o_pc_load, .o_pc_value, .o_brownout_reset);
